// *** design/rjc_regs.svh ***
/*
 Register offsets, field positions, reset values and scale counts of the
 resistance judgment and conversion block. Included by its bare name.
*/
`ifndef RJC_REGS_SVH
`define RJC_REGS_SVH
// Register byte offsets
`define RJC_A_CTRL 8'h00
`define RJC_A_UPPER 8'h04
`define RJC_A_LOWER 8'h08
`define RJC_A_REF 8'h0c
`define RJC_A_PCT 8'h10
`define RJC_A_CONFIRM 8'h14
`define RJC_A_RANGE 8'h18
`define RJC_A_PERM 8'h1c
`define RJC_A_R1 8'h20
`define RJC_A_T1 8'h24
`define RJC_A_STATUS 8'h28
`define RJC_A_CONV 8'h2c
// Control field positions
`define RJC_C_COMP 0
`define RJC_C_RELM 1
`define RJC_C_SOUND 2
`define RJC_C_TRISE 3
`define RJC_C_LEN 4
`define RJC_C_HICUR 5
`define RJC_C_TCOR 6
`define RJC_C_IVL 7
// Reset values
`define RJC_CTRL_RST 8'h00
`define RJC_RANGE_RST 5'h10
// Range code of the range with a current choice
`define RJC_RANGE_LOWOHM 4'h2
// Relative scale: hundredths of a percent
`define RJC_PCT_SCALE 64'sd10000
// Length result in thousandths of a metre
`define RJC_LEN_SCALE 64'sd1000
`endif

// *** design/rjc_pkg.sv ***
/*
 Types of the resistance judgment and conversion block.
 Assumes nothing of its surroundings.
*/
package rjc_pkg;
  // Judgment result
  typedef enum logic [1:0] {
    RJC_J_NONE = 2'h0,
    RJC_J_HI = 2'h1,
    RJC_J_IN = 2'h2,
    RJC_J_LO = 2'h3
  } rjc_judge_t;
  // Which conversion feeds the shared divider
  typedef enum logic [2:0] {
    RJC_V_REL = 3'h1,
    RJC_V_LEN = 3'h2,
    RJC_V_TRISE = 3'h4
  } rjc_conv_t;
endpackage : rjc_pkg

// *** design/rjc_judge.sv ***
/*
 Comparator judgment, lamp and buzzer drive, resistance conversions and the
 interlocks among comparator, conversions, range and interval memory, plus
 test current selection. Assumes readings arrive as one-cycle strobes from
 logic on the same clock, and that edit_abort comes from the power
 supervisor on the same clock.
*/
// Implementation choices: the register offsets and strobed register access.
// Overview of operation
// - Valid reading judged high, within or low
// - Overrange maps to high/low, blank gives none
// - Measurement error skips judgment entirely
// - Any conversion on forces comparator off
// - Comparator on rejects every range change
// - Comparator on makes interval memory unavailable
// - Limit and reference edits apply on confirm, discarded on abort
// - Absolute mode compares against stored limits
// - Relative mode derives limits from reference
// - Refuse absolute limits with upper below lower
// - Relative value is reading/ref minus one
// - Refuse relative settings with zero reference
// - Optional judgment buzzer, off after reset
// - Lamp green within, red high or low
// - Temperature rise blocks comparator and correction
// - Temperature rise and length exclude each other
// - Length conversion blocks comparator turn-on
// - Length is reading over per-metre resistance
// - Temperature rise uses stored R1 and t1
// - Low-ohm range current selectable low/high
// - Current change clears zero adjustment
// - High current lights its indicator in the low-ohm range only
`timescale 1ns/1ps
`include "rjc_regs.svh"
module rjc_judge import rjc_pkg::*; #(
  parameter logic signed [31:0] TR_K = 32'sd2345 // Tenths of a degree
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Readings from the measurement path
  input wire logic rd_valid,
  input wire logic signed [31:0] rd_value,
  input wire logic rd_over_pos,
  input wire logic rd_over_neg,
  input wire logic rd_blank,
  input wire logic meas_error,
  input wire logic signed [15:0] amb_temp,
  input wire logic edit_abort,
  // Judgment outputs
  output logic judge_hi,
  output logic judge_in,
  output logic judge_lo,
  output logic lamp_green,
  output logic lamp_red,
  output logic buzzer,
  // Measurement control outputs
  output logic zero_clear,
  output logic hi_current_led,
  output logic hi_current,
  output logic interval_on,
  output logic [4:0] range_sel,
  output logic signed [31:0] conv_value
);

  // Shared signed divide, zero divisor yields zero
  function automatic logic signed [31:0] sdiv(input logic signed [63:0] n,
                                              input logic signed [63:0] d);
    logic signed [63:0] q;
    q = (d == 64'sd0) ? 64'sd0 : n / d;
    return q[31:0];
  endfunction : sdiv

  // Control and setting state
  logic comp_r, comp_nxt, relm_r, relm_nxt, snd_r, snd_nxt;
  logic trise_r, trise_nxt, len_r, len_nxt, hic_r, hic_nxt;
  logic tcor_r, tcor_nxt, ivl_r, ivl_nxt;
  logic [4:0] range_r, range_nxt;
  logic signed [31:0] up_e_r, up_e_nxt, lo_e_r, lo_e_nxt;
  logic signed [31:0] ref_e_r, ref_e_nxt;
  logic [15:0] pct_e_r, pct_e_nxt;
  logic signed [31:0] up_r, up_nxt, lo_r, lo_nxt, ref_r, ref_nxt;
  logic [15:0] pct_r, pct_nxt;
  logic signed [31:0] pm_r, pm_nxt, r1_r, r1_nxt;
  logic signed [15:0] t1_r, t1_nxt;
  logic rng_rej_r, rng_rej_nxt, on_rej_r, on_rej_nxt;
  logic cfm_rej_r, cfm_rej_nxt, zclr_r, zclr_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  // Judgment and conversion state
  rjc_judge_t judge_r, judge_nxt;
  logic green_r, green_nxt, red_r, red_nxt, buz_r, buz_nxt;
  logic hled_r, hled_nxt;
  logic [2:0] jv_r, jv_nxt; // Registered hi, in, lo levels
  logic signed [31:0] conv_r, conv_nxt;
  // Decode and request terms
  logic wr_ctrl, wr_sts, t_on, l_on;
  logic [7:0] w;
  logic signed [63:0] hi_lim, lo_lim, rd_s, num, den;
  rjc_conv_t vsel;

  assign wr_ctrl = reg_wr && reg_addr == `RJC_A_CTRL;
  assign wr_sts = reg_wr && reg_addr == `RJC_A_STATUS;
  assign w = reg_wdata[7:0];
  // Newly requested conversions
  assign t_on = wr_ctrl && w[`RJC_C_TRISE] && !trise_r;
  assign l_on = wr_ctrl && w[`RJC_C_LEN] && !len_r && !t_on;

  // Control interlocks
  always_comb begin
    comp_nxt = comp_r;
    relm_nxt = relm_r;
    snd_nxt = snd_r;
    trise_nxt = trise_r;
    len_nxt = len_r;
    hic_nxt = hic_r;
    tcor_nxt = tcor_r;
    ivl_nxt = ivl_r;
    range_nxt = range_r;
    on_rej_nxt = on_rej_r && !(wr_sts && reg_wdata[1]);
    rng_rej_nxt = rng_rej_r && !(wr_sts && reg_wdata[0]);
    zclr_nxt = 1'b0;
    if (wr_ctrl) begin
      relm_nxt = w[`RJC_C_RELM];
      snd_nxt = w[`RJC_C_SOUND];
      trise_nxt = w[`RJC_C_TRISE] && !l_on;
      len_nxt = w[`RJC_C_LEN] && !t_on;
      hic_nxt = w[`RJC_C_HICUR];
      zclr_nxt = w[`RJC_C_HICUR] != hic_r;
      if (t_on || l_on) begin
        comp_nxt = 1'b0;
      end else if (w[`RJC_C_COMP] && !comp_r && (trise_nxt || len_nxt || ivl_r)) begin
        comp_nxt = 1'b0;
        on_rej_nxt = 1'b1;
      end else begin
        comp_nxt = w[`RJC_C_COMP];
      end
      if (w[`RJC_C_TCOR] && !tcor_r && trise_nxt) begin
        tcor_nxt = 1'b0;
        on_rej_nxt = 1'b1;
      end else begin
        tcor_nxt = w[`RJC_C_TCOR];
      end
      if (w[`RJC_C_IVL] && !ivl_r && comp_nxt) begin
        ivl_nxt = 1'b0;
        on_rej_nxt = 1'b1;
      end else begin
        ivl_nxt = w[`RJC_C_IVL];
      end
    end
    if (reg_wr && reg_addr == `RJC_A_RANGE) begin
      if (comp_r) begin
        rng_rej_nxt = 1'b1;
      end else begin
        range_nxt = reg_wdata[4:0];
      end
    end
  end

  // Staged limit and reference edits, commit on confirm; per-metre, R1 and t1 settings apply at once
  always_comb begin
    up_e_nxt = up_e_r;
    lo_e_nxt = lo_e_r;
    ref_e_nxt = ref_e_r;
    pct_e_nxt = pct_e_r;
    up_nxt = up_r;
    lo_nxt = lo_r;
    ref_nxt = ref_r;
    pct_nxt = pct_r;
    pm_nxt = pm_r;
    r1_nxt = r1_r;
    t1_nxt = t1_r;
    cfm_rej_nxt = cfm_rej_r && !(wr_sts && reg_wdata[2]);
    if (reg_wr) begin
      unique case (reg_addr)
        `RJC_A_UPPER: up_e_nxt = reg_wdata;
        `RJC_A_LOWER: lo_e_nxt = reg_wdata;
        `RJC_A_REF: ref_e_nxt = reg_wdata;
        `RJC_A_PCT: pct_e_nxt = reg_wdata[15:0];
        `RJC_A_PERM: pm_nxt = reg_wdata;
        `RJC_A_R1: r1_nxt = reg_wdata;
        `RJC_A_T1: t1_nxt = reg_wdata[15:0];
        `RJC_A_CONFIRM: begin
          if (!relm_r && up_e_r < lo_e_r) begin
            cfm_rej_nxt = 1'b1;
          end else if (relm_r && ref_e_r == 32'sd0) begin
            cfm_rej_nxt = 1'b1;
          end else if (relm_r) begin
            ref_nxt = ref_e_r;
            pct_nxt = pct_e_r;
          end else begin
            up_nxt = up_e_r;
            lo_nxt = lo_e_r;
          end
        end
        default: ;
      endcase
    end
    if (edit_abort) begin
      up_e_nxt = up_r;
      lo_e_nxt = lo_r;
      ref_e_nxt = ref_r;
      pct_e_nxt = pct_r;
    end
  end

  // Limits in working scale; relative ones derive from the reference
  always_comb begin
    rd_s = 64'(rd_value);
    if (relm_r) begin
      hi_lim = 64'(ref_r) * (`RJC_PCT_SCALE + 64'(pct_r));
      lo_lim = 64'(ref_r) * (`RJC_PCT_SCALE - 64'(pct_r));
      rd_s = 64'(rd_value) * `RJC_PCT_SCALE;
    end else begin
      hi_lim = 64'(up_r);
      lo_lim = 64'(lo_r);
    end
  end

  // Judgment, lamp and buzzer
  always_comb begin
    judge_nxt = judge_r;
    if (!comp_r) begin
      judge_nxt = RJC_J_NONE;
    end else if (rd_valid) begin
      if (meas_error) begin
        judge_nxt = RJC_J_NONE;
      end else if (rd_over_pos) begin
        judge_nxt = RJC_J_HI;
      end else if (rd_over_neg) begin
        judge_nxt = RJC_J_LO;
      end else if (rd_blank) begin
        judge_nxt = RJC_J_NONE;
      end else if (rd_s > hi_lim) begin
        judge_nxt = RJC_J_HI;
      end else if (rd_s < lo_lim) begin
        judge_nxt = RJC_J_LO;
      end else begin
        judge_nxt = RJC_J_IN;
      end
    end
    green_nxt = judge_nxt == RJC_J_IN;
    red_nxt = judge_nxt == RJC_J_HI || judge_nxt == RJC_J_LO;
    buz_nxt = snd_nxt && red_nxt;
    hled_nxt = hic_nxt && range_nxt[3:0] == `RJC_RANGE_LOWOHM;
    jv_nxt = {judge_nxt == RJC_J_HI, judge_nxt == RJC_J_IN, judge_nxt == RJC_J_LO};
  end

  // Conversion through one divider
  always_comb begin
    if (trise_r) begin
      vsel = RJC_V_TRISE;
    end else if (len_r) begin
      vsel = RJC_V_LEN;
    end else begin
      vsel = RJC_V_REL;
    end
    unique case (vsel)
      RJC_V_TRISE: begin
        num = 64'(rd_value) * (64'(TR_K) + 64'(t1_r));
        den = 64'(r1_r);
      end
      RJC_V_LEN: begin
        num = 64'(rd_value) * `RJC_LEN_SCALE;
        den = 64'(pm_r);
      end
      RJC_V_REL: begin
        num = (64'(rd_value) - 64'(ref_r)) * `RJC_PCT_SCALE;
        den = 64'(ref_r);
      end
    endcase
    conv_nxt = conv_r;
    if (rd_valid && !meas_error && !rd_blank) begin
      conv_nxt = sdiv(num, den);
      if (vsel == RJC_V_TRISE) begin
        conv_nxt = sdiv(num, den) - TR_K - 32'(amb_temp);
      end
    end
  end

  // Read data, valid the cycle after the strobe
  always_comb begin
    rdata_nxt = 32'h0;
    if (reg_rd) begin
      unique case (reg_addr)
        `RJC_A_CTRL: rdata_nxt = {24'h0, ivl_r, tcor_r, hic_r, len_r, trise_r, snd_r, relm_r, comp_r};
        `RJC_A_UPPER: rdata_nxt = up_e_r;
        `RJC_A_LOWER: rdata_nxt = lo_e_r;
        `RJC_A_REF: rdata_nxt = ref_e_r;
        `RJC_A_PCT: rdata_nxt = {16'h0, pct_e_r};
        `RJC_A_RANGE: rdata_nxt = {27'h0, range_r};
        `RJC_A_PERM: rdata_nxt = pm_r;
        `RJC_A_R1: rdata_nxt = r1_r;
        `RJC_A_T1: rdata_nxt = {{16{t1_r[15]}}, t1_r};
        `RJC_A_STATUS: rdata_nxt = {27'h0, judge_r, cfm_rej_r, on_rej_r, rng_rej_r};
        `RJC_A_CONV: rdata_nxt = conv_r;
        default: rdata_nxt = 32'h0;
      endcase
    end
  end

  // State registers
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      // Everything clears except range, which loads RJC_RANGE_RST; judgment sound and high current start off
      {comp_r, relm_r, snd_r, trise_r, len_r, hic_r, tcor_r, ivl_r} <= 8'h0;
      {rng_rej_r, on_rej_r, cfm_rej_r, zclr_r, green_r, red_r, buz_r, hled_r} <= 8'h0;
      {up_e_r, lo_e_r, ref_e_r, up_r, lo_r, ref_r} <= 192'h0;
      {pm_r, r1_r, conv_r, rdata_r} <= 128'h0;
      {pct_e_r, pct_r, t1_r} <= 48'h0;
      range_r <= `RJC_RANGE_RST;
      judge_r <= RJC_J_NONE;
      jv_r <= 3'h0;
    end else begin
      {comp_r, relm_r, snd_r, trise_r, len_r, hic_r, tcor_r, ivl_r} <=
        {comp_nxt, relm_nxt, snd_nxt, trise_nxt, len_nxt, hic_nxt, tcor_nxt, ivl_nxt};
      {rng_rej_r, on_rej_r, cfm_rej_r, zclr_r, green_r, red_r, buz_r, hled_r} <=
        {rng_rej_nxt, on_rej_nxt, cfm_rej_nxt, zclr_nxt, green_nxt, red_nxt, buz_nxt, hled_nxt};
      {up_e_r, lo_e_r, ref_e_r, up_r, lo_r, ref_r} <=
        {up_e_nxt, lo_e_nxt, ref_e_nxt, up_nxt, lo_nxt, ref_nxt};
      {pm_r, r1_r, conv_r, rdata_r} <= {pm_nxt, r1_nxt, conv_nxt, rdata_nxt};
      {pct_e_r, pct_r, t1_r} <= {pct_e_nxt, pct_nxt, t1_nxt};
      range_r <= range_nxt;
      judge_r <= judge_nxt;
      jv_r <= jv_nxt;
    end
  end

  // Outputs straight from flip-flops
  assign reg_rdata = rdata_r;
  assign judge_hi = jv_r[2];
  assign judge_in = jv_r[1];
  assign judge_lo = jv_r[0];
  assign lamp_green = green_r;
  assign lamp_red = red_r;
  assign buzzer = buz_r;
  assign zero_clear = zclr_r;
  assign hi_current_led = hled_r;
  assign hi_current = hic_r;
  assign interval_on = ivl_r;
  assign range_sel = range_r;
  assign conv_value = conv_r;

  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  sequence s_confirm;
    reg_wr && reg_addr == `RJC_A_CONFIRM;
  endsequence
  sequence s_clean_read;
    comp_r && rd_valid && !meas_error && !rd_over_pos && !rd_over_neg && !rd_blank;
  endsequence

  a_error_no_judge: assert property (comp_r && rd_valid && meas_error |=> judge_r == RJC_J_NONE)
    else $error("judgment made during measurement error");
  a_over_pos_high: assert property (comp_r && rd_valid && !meas_error && rd_over_pos |=> judge_hi)
    else $error("positive overrange not judged high");
  a_equal_within: assert property (s_clean_read and (!relm_r && rd_value == up_r && up_r >= lo_r) |=> judge_in)
    else $error("reading at upper limit not within");
  a_above_high: assert property (s_clean_read and (!relm_r && rd_value > up_r) |=> judge_hi)
    else $error("reading above upper limit not high");
  a_lamp_follows: assert property (judge_r != RJC_J_NONE |-> lamp_green == judge_in && lamp_red == !judge_in)
    else $error("lamp colour disagrees with judgment");
  a_range_locked: assert property (comp_r && reg_wr && reg_addr == `RJC_A_RANGE |=> $stable(range_sel) && rng_rej_r)
    else $error("range changed while comparator on");
  a_conv_exclusive: assert property (!(trise_r && len_r))
    else $error("both conversions on");
  a_conv_comp_off: assert property ($rose(trise_r) || $rose(len_r) |-> !comp_r)
    else $error("comparator left on by conversion");
  a_ivl_comp: assert property (!(comp_r && $rose(ivl_r)) && !(ivl_r && $rose(comp_r)))
    else $error("interval memory and comparator both turned on");
  a_abs_bad_kept: assert property (s_confirm and (!relm_r && up_e_r < lo_e_r) |=> $stable(up_r) && $stable(lo_r))
    else $error("inverted limits committed");
  a_ref_zero_kept: assert property (s_confirm and (relm_r && ref_e_r == 32'sd0) |=> $stable(ref_r) && cfm_rej_r)
    else $error("zero reference committed");
  a_zero_clear: assert property (wr_ctrl && w[`RJC_C_HICUR] != hi_current |=> zero_clear ##1 !zero_clear)
    else $error("current change without one zero clear pulse");
  a_hi_led: assert property (hi_current_led |-> hi_current && range_sel[3:0] == `RJC_RANGE_LOWOHM)
    else $error("high current indicator without high current");

endmodule : rjc_judge

// *** tb/rjc_lamp_model.sv ***
/*
 Model of the external two-colour judgment lamp on the comparator output.
 Assumes the lamp drive pins of the judgment block, active high levels.
*/
`timescale 1ns/1ps
module rjc_lamp_model (
  // Lamp drive from the device
  input wire logic lamp_green,
  input wire logic lamp_red,
  // Seen colour: 1 green, 2 red, 3 both lit (never legal), 0 dark
  output logic [1:0] colour
);
  // Each die of the lamp follows its own drive line
  assign colour = {lamp_red, lamp_green};
endmodule : rjc_lamp_model

// *** tb/rjc_judge_tb.sv ***
/*
 Self-checking bench of the judgment and conversion block: register tasks,
 reading strobes and a lamp model. Assumes one 250 MHz clock.
*/
`timescale 1ns/1ps
`include "rjc_regs.svh"
module rjc_judge_tb;
  // Judgment vectors: hi, in, lo, lamp colour, buzzer
  localparam logic [5:0] J_HI = 6'b100101;
  localparam logic [5:0] J_IN = 6'b010010;
  localparam logic [5:0] J_LO = 6'b001101;
  localparam logic [5:0] J_NO = 6'b000000;
  logic clock, reset_n, reg_wr, reg_rd, rd_valid, edit_abort;
  logic rd_over_pos, rd_over_neg, rd_blank, meas_error;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic signed [31:0] rd_value, conv_value;
  logic signed [15:0] amb_temp;
  logic judge_hi, judge_in, judge_lo, lamp_green, lamp_red, buzzer;
  logic zero_clear, hi_current_led, hi_current, interval_on;
  logic [4:0] range_sel;
  logic [1:0] colour;
  int n_fail, tests_run, cyc, zc_n, z0;

  rjc_judge #(.TR_K(32'sd2345)) uut (.clock(clock), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .rd_valid(rd_valid), .rd_value(rd_value), .rd_over_pos(rd_over_pos), .rd_over_neg(rd_over_neg),
    .rd_blank(rd_blank), .meas_error(meas_error), .amb_temp(amb_temp), .edit_abort(edit_abort),
    .judge_hi(judge_hi), .judge_in(judge_in), .judge_lo(judge_lo), .lamp_green(lamp_green),
    .lamp_red(lamp_red), .buzzer(buzzer), .zero_clear(zero_clear), .hi_current_led(hi_current_led),
    .hi_current(hi_current), .interval_on(interval_on), .range_sel(range_sel), .conv_value(conv_value));
  rjc_lamp_model lamp (.lamp_green(lamp_green), .lamp_red(lamp_red), .colour(colour));

  // Clock, 4 ns period
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  // Hang guard and zero-clear pulse counter
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (zero_clear === 1'b1) zc_n <= zc_n + 1;
    if (cyc == 20000) begin
      n_fail++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("checks %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_j(input logic [5:0] exp);
    chk({26'h0, judge_hi, judge_in, judge_lo, colour, buzzer}, {26'h0, exp});
  endtask : chk_j

  // One-cycle write, then an idle edge before the next strobe
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    @(posedge clock);
  endtask : wr

  // One-cycle read; data is looked at in the following cycle only
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
    @(posedge clock);
  endtask : rd

  // Reading strobe with qualifiers {error, blank, neg over, pos over}
  task automatic meas(input logic signed [31:0] v, input logic [3:0] f, input logic [5:0] exp);
    rd_value <= v;
    {meas_error, rd_blank, rd_over_neg, rd_over_pos} <= f;
    rd_valid <= 1'b1;
    @(posedge clock);
    rd_valid <= 1'b0;
    #1;
    chk_j(exp);
    @(posedge clock);
  endtask : meas

  // Staged-edit discard by a power-down notice
  task automatic abort_pulse();
    edit_abort <= 1'b1;
    @(posedge clock);
    edit_abort <= 1'b0;
    @(posedge clock);
  endtask : abort_pulse

  initial begin
    {reset_n, reg_wr, reg_rd, rd_valid, edit_abort} = 5'h00;
    {rd_over_pos, rd_over_neg, rd_blank, meas_error} = 4'h0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    rd_value = 32'sh0;
    amb_temp = 16'sd250;
    {n_fail, tests_run, cyc, zc_n} = '0;
    repeat (5) @(posedge clock);
    reset_n <= 1'b1;
    @(posedge clock);
    // Reset state
    rd(`RJC_A_CTRL, 32'h0);
    chk({27'h0, range_sel}, 32'h10);
    rd(8'h40, 32'h0);
    // Absolute limits 80..100
    wr(`RJC_A_UPPER, 32'd100);
    wr(`RJC_A_LOWER, 32'd80);
    wr(`RJC_A_CONFIRM, 32'h1);
    wr(`RJC_A_CTRL, 32'h05);
    meas(32'sd101, 4'h0, J_HI);
    meas(32'sd100, 4'h0, J_IN);
    meas(32'sd90, 4'h0, J_IN);
    meas(32'sd80, 4'h0, J_IN);
    meas(32'sd79, 4'h0, J_LO);
    meas(32'sd0, 4'h1, J_HI);
    meas(32'sd0, 4'h2, J_LO);
    meas(32'sd90, 4'h4, J_NO);
    meas(32'sd90, 4'h9, J_NO);
    // Range and interval locked while comparing
    wr(`RJC_A_RANGE, 32'h03);
    chk({27'h0, range_sel}, 32'h10);
    wr(`RJC_A_CTRL, 32'h85);
    chk({31'h0, interval_on}, 32'h0);
    rd(`RJC_A_STATUS, 32'h03);
    wr(`RJC_A_STATUS, 32'h03);
    // Upper below lower is refused, old limits stay
    wr(`RJC_A_UPPER, 32'd50);
    wr(`RJC_A_LOWER, 32'd60);
    wr(`RJC_A_CONFIRM, 32'h1);
    rd(`RJC_A_STATUS, 32'h04);
    meas(32'sd70, 4'h0, J_LO);
    wr(`RJC_A_STATUS, 32'h04);
    // Abort discards staged edits
    wr(`RJC_A_UPPER, 32'd200);
    wr(`RJC_A_LOWER, 32'd80);
    abort_pulse();
    wr(`RJC_A_CONFIRM, 32'h1);
    meas(32'sd150, 4'h0, J_HI);
    // Relative mode, reference 1000, 10.00 percent
    wr(`RJC_A_CTRL, 32'h07);
    wr(`RJC_A_REF, 32'd1000);
    wr(`RJC_A_PCT, 32'd1000);
    wr(`RJC_A_CONFIRM, 32'h1);
    meas(32'sd1100, 4'h0, J_IN);
    chk(conv_value, 32'd1000);
    meas(32'sd1101, 4'h0, J_HI);
    meas(32'sd899, 4'h0, J_LO);
    chk(conv_value, 32'hfffffc0e);
    wr(`RJC_A_REF, 32'd0);
    wr(`RJC_A_CONFIRM, 32'h1);
    rd(`RJC_A_STATUS, 32'h1c);
    meas(32'sd1200, 4'h0, J_HI);
    wr(`RJC_A_STATUS, 32'h04);
    // Sound off: red lamp without buzzer
    wr(`RJC_A_CTRL, 32'h03);
    meas(32'sd1200, 4'h0, 6'b100100);
    // Conversions and their interlocks
    wr(`RJC_A_CTRL, 32'h0d);
    rd(`RJC_A_CTRL, 32'h0c);
    chk_j(J_NO);
    wr(`RJC_A_CTRL, 32'h1d);
    rd(`RJC_A_CTRL, 32'h14);
    wr(`RJC_A_CTRL, 32'h4c);
    rd(`RJC_A_CTRL, 32'h0c);
    wr(`RJC_A_CTRL, 32'h0d);
    rd(`RJC_A_CTRL, 32'h0c);
    wr(`RJC_A_R1, 32'd1000);
    wr(`RJC_A_T1, 32'd200);
    meas(32'sd1200, 4'h0, J_NO);
    chk(conv_value, 32'd459);
    wr(`RJC_A_CTRL, 32'h14);
    rd(`RJC_A_CTRL, 32'h14);
    wr(`RJC_A_CTRL, 32'h15);
    rd(`RJC_A_CTRL, 32'h14);
    wr(`RJC_A_PERM, 32'd200);
    meas(32'sd15000, 4'h0, J_NO);
    chk(conv_value, 32'd75000);
    rd(`RJC_A_CONV, 32'd75000);
    // Test current choice in the low-ohm range
    wr(`RJC_A_CTRL, 32'h00);
    wr(`RJC_A_RANGE, 32'h02);
    chk({27'h0, range_sel}, 32'h02);
    z0 = zc_n;
    wr(`RJC_A_CTRL, 32'h20);
    repeat (3) @(posedge clock);
    chk(zc_n - z0, 32'd1);
    chk({30'h0, hi_current, hi_current_led}, 32'h3);
    wr(`RJC_A_CTRL, 32'h20);
    repeat (3) @(posedge clock);
    chk(zc_n - z0, 32'd1);
    wr(`RJC_A_RANGE, 32'h03);
    chk({30'h0, hi_current, hi_current_led}, 32'h2);
    wr(`RJC_A_CTRL, 32'h00);
    repeat (3) @(posedge clock);
    chk(zc_n - z0, 32'd2);
    chk({30'h0, hi_current, hi_current_led}, 32'h0);
    stop_test();
  end
endmodule : rjc_judge_tb
